// ==== design/pfs_pkg.sv ====
package pfs_pkg;

   // Pin bank geometry
   localparam int unsigned PFS_NPINS     = 5;
   localparam int unsigned PFS_SEL_W     = 3;
   localparam int unsigned PFS_FUNC_W    = 15;
   localparam int unsigned PFS_DATA_W    = 32;
   localparam int unsigned PFS_ADDR_W    = 8;
   localparam int unsigned PFS_NCODES    = 8;

   // Configuration space offsets
   localparam logic [7:0]  PFS_OFF_FUNC_SEL = 8'hc0;
   localparam logic [7:0]  PFS_OFF_PIN_DATA = 8'hc4;

   // Field layout of the function-select and pin data registers, and reset values
   localparam int unsigned PFS_RSVD_BIT      = 15;
   localparam int unsigned PFS_FLD_LSB [PFS_NPINS] = '{0, 3, 6, 9, 12};
   localparam int unsigned PFS_DATA_LSB      = 10;
   localparam logic [14:0] PFS_FUNC_SEL_RST  = 15'h0000;
   localparam logic [4:0]  PFS_GP_OUT_RST    = 5'h00;

   // Selector codes
   typedef enum logic [2:0] {
      PFS_SEL_GP_IN  = 3'b000,
      PFS_SEL_GP_OUT = 3'b001,
      PFS_SEL_ALT2   = 3'b010,
      PFS_SEL_ALT3   = 3'b011,
      PFS_SEL_ALT4   = 3'b100,
      PFS_SEL_ALT5   = 3'b101,
      PFS_SEL_ALT6   = 3'b110,
      PFS_SEL_ALT7   = 3'b111
   } pfs_sel_t;

   // Codes that make each pin drive, bit index is the code; pins 10..14
   localparam logic [7:0] PFS_OUT_MASK [PFS_NPINS] = '{8'h02, 8'h02, 8'hfe, 8'hfe, 8'h7e};

   // Positions of the pin-sourced hot-plug signals in the core-side vector
   localparam int unsigned PFS_HP_PF1   = 0;
   localparam int unsigned PFS_HP_PF2   = 1;
   localparam int unsigned PFS_HP_PF3   = 2;
   localparam int unsigned PFS_HP_CKR3  = 3;
   localparam int unsigned PFS_HP_LAT1  = 4;
   localparam int unsigned PFS_HP_LAT2  = 5;
   localparam int unsigned PFS_HP_LAT3  = 6;
   localparam int unsigned PFS_HP_BTN1  = 7;
   localparam int unsigned PFS_HP_BTN2  = 8;
   localparam int unsigned PFS_HP_PGD3  = 9;
   localparam int unsigned PFS_HP_W     = 10;

endpackage

// ==== design/pfs_pin_cell.sv ====
`timescale 1ns/100ps

module pfs_pin_cell
   import pfs_pkg::*;
#(
   parameter logic [7:0] P_OUT_MASK = 8'h02  // Codes for which the pin drives
) (
   input  wire logic       i_clk,       // Core clock
   input  wire logic       i_rst_n,     // Synchronised reset, active low
   input  wire logic       i_ce,        // Clock enable
   input  wire logic [2:0] i_sel,       // Pin selector code
   input  wire logic [7:0] i_func,      // Output function per code
   input  wire logic       i_gp_out,    // General output latch
   input  wire logic       i_force_in,  // Strap holds the pin as input
   output logic            o_pin_out,   // Pin output level
   output logic            o_pin_oe_n   // Output enable, low drives
);

   typedef struct packed {
      logic out;
      logic oe_n;
   } pfs_cell_t;

   pfs_cell_t q;
   pfs_cell_t d;

   // Direction and level follow the selector; idle pins park low and undriven
   always_comb begin
      d = q;
      d.oe_n = !(P_OUT_MASK[i_sel] && !i_force_in);
      if (i_sel == PFS_SEL_GP_OUT) begin
         d.out = i_gp_out;
      end else begin
         d.out = i_func[i_sel];
      end
      if (d.oe_n) begin
         d.out = 1'b0;
      end
   end

   // Registered drive keeps the pin free of selector glitches
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '{out: 1'b0, oe_n: 1'b1};
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_pin_out  = q.out;
   assign o_pin_oe_n = q.oe_n;

endmodule

// ==== design/pfs_function_select.sv ====
// Contract
// R1: Bit 15 of the function-select register always reads zero and writes to it are dropped.
// R2: Code 000 is general input (reset value), 001 general output; the register resets to 0.
// R3: Pin 14: 010..100 give activity 1..3, 101/110 power 1/2, 111 port 3 power fault.
// R4: Pin 13: 010..100 give activity 1..3, 101 attention 1, 110 power 2, 111 alt power 3.
// R5: Pin 12: 010..100 give activity 1..3, 101 power 1, 110 attention 2, 111 alt attention 3.
// R6: Pin 11: 010 clock request 3, 011 latch 3, 100/101 fault 1/2, 110/111 latch 1/2.
// R7: Pin 10 codes 010/011 button 1/2, 100/101 power fault 1/2, 110/111 latch sensor 1/2.
// R8: Every selector field loads from the EEPROM when present and clears on fundamental reset.
// R9: With the port 3 strap high at reset release, pin 10 is only the port 3 power-good input.
// R10: Software leaves the pin 10 selector at default while the strap owns that pin.
// R11: Reading pin data returns the real level of every pin whatever its function.
// R12: Writing pin data changes only pins whose selector picks general output.
`timescale 1ns/100ps

module pfs_function_select
   import pfs_pkg::*;
(
   input  wire logic        i_clk,                       // Core clock, 200 MHz
   input  wire logic        i_rst_n,                     // Fundamental reset, active low
   input  wire logic        i_ce,                        // Clock enable
   input  wire logic        i_cfg_wr,                    // Config write strobe
   input  wire logic        i_cfg_rd,                    // Config read strobe
   input  wire logic [7:0]  i_cfg_addr,                  // Dword-aligned byte address
   input  wire logic [3:0]  i_cfg_be,                    // Byte enables
   input  wire logic [31:0] i_cfg_wdata,                 // Write data
   output logic [31:0]      o_cfg_rdata,                 // Read data
   output logic             o_cfg_rvalid,                // Read data valid pulse
   input  wire logic        i_eeprom_load,               // EEPROM word strobe
   input  wire logic [15:0] i_eeprom_word,               // EEPROM word for this register
   input  wire logic        i_port3_hotplug_strap,       // Strap, caught at reset release
   input  wire logic [4:0]  i_pin_in,                    // Pin levels, pins 10..14
   output logic [4:0]       o_pin_out,                   // Pin drive levels
   output logic [4:0]       o_pin_oe_n,                  // Pin output enables, low drives
   input  wire logic        i_port1_activity_indicator,  // Indicator sources
   input  wire logic        i_port2_activity_indicator,  // Port 2 activity
   input  wire logic        i_port3_activity_indicator,  // Port 3 activity
   input  wire logic        i_port1_power_indicator,     // Port 1 power
   input  wire logic        i_port2_power_indicator,     // Port 2 power
   input  wire logic        i_port3_power_indicator_alt, // Port 3 power, index 1 variant
   input  wire logic        i_port1_attention_indicator, // Port 1 attention
   input  wire logic        i_port2_attention_indicator, // Port 2 attention
   input  wire logic        i_port3_attention_indicator_alt, // Port 3 attention, index 1
   output logic             o_port1_power_fault,         // Pin-sourced hot-plug inputs
   output logic             o_port2_power_fault,         // Port 2 power fault
   output logic             o_port3_power_fault,         // Port 3 power fault
   output logic             o_port3_clock_request,       // Port 3 clock request
   output logic             o_port1_latch_sensor,        // Port 1 latch sensor
   output logic             o_port2_latch_sensor,        // Port 2 latch sensor
   output logic             o_port3_latch_sensor,        // Port 3 latch sensor
   output logic             o_port1_attention_button,    // Port 1 attention button
   output logic             o_port2_attention_button,    // Port 2 attention button
   output logic             o_port3_power_good           // Strapped power-good input
);

   typedef struct packed {
      logic [14:0]         sel;
      logic [4:0]          gp_out;
      logic [4:0]          pin_in;
      logic                strap;
      logic                strap_done;
      logic [PFS_HP_W-1:0] hp;
      logic [31:0]         rdata;
      logic                rvalid;
   } pfs_state_t;

   pfs_state_t q;
   pfs_state_t d;
   logic       rst_meta_q;
   logic       rst_sync_q;
   logic [2:0] sel_f   [PFS_NPINS];
   logic [4:0] gp_mode;
   logic [7:0] func_vec [PFS_NPINS];

   // Reset release through two flops; the first is read by the second only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Per-pin selector slice, general output flag and drive cell
   for (genvar g = 0; g < PFS_NPINS; g++) begin : g_pin
      assign sel_f[g]   = q.sel[PFS_FLD_LSB[g] +: PFS_SEL_W];
      assign gp_mode[g] = (sel_f[g] == PFS_SEL_GP_OUT) && !((g == 0) && q.strap); // R12
      pfs_pin_cell #(
         .P_OUT_MASK (PFS_OUT_MASK[g])
      ) pfs_pin_cell_i (
         .i_clk      (i_clk),
         .i_rst_n    (rst_sync_q),
         .i_ce       (i_ce),
         .i_sel      (sel_f[g]),
         .i_func     (func_vec[g]),
         .i_gp_out   (q.gp_out[g]),
         .i_force_in ((g == 0) && q.strap),
         .o_pin_out  (o_pin_out[g]),
         .o_pin_oe_n (o_pin_oe_n[g])
      );

      AST_GPIN_UNDRIVEN: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
         (i_ce && sel_f[g] == PFS_SEL_GP_IN) |=> o_pin_oe_n[g])  // R2
         else $error("general input pin is driven");
      AST_GPOUT_DRIVES: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
         (i_ce && gp_mode[g]) |=> (!o_pin_oe_n[g] && o_pin_out[g] == $past(q.gp_out[g])))  // R2
         else $error("general output pin does not follow its latch");
   end

   // Indicator sources per code; input-only codes leave their slots at zero
   always_comb begin
      for (int p = 0; p < PFS_NPINS; p++) begin
         func_vec[p] = 8'h00;
      end
      func_vec[4][2] = i_port1_activity_indicator;  // R3
      func_vec[4][3] = i_port2_activity_indicator;
      func_vec[4][4] = i_port3_activity_indicator;
      func_vec[4][5] = i_port1_power_indicator;
      func_vec[4][6] = i_port2_power_indicator;
      func_vec[3][2] = i_port1_activity_indicator;  // R4
      func_vec[3][3] = i_port2_activity_indicator;
      func_vec[3][4] = i_port3_activity_indicator;
      func_vec[3][5] = i_port1_attention_indicator;
      func_vec[3][6] = i_port2_power_indicator;
      func_vec[3][7] = i_port3_power_indicator_alt;
      func_vec[2][2] = i_port1_activity_indicator;  // R5
      func_vec[2][3] = i_port2_activity_indicator;
      func_vec[2][4] = i_port3_activity_indicator;
      func_vec[2][5] = i_port1_power_indicator;
      func_vec[2][6] = i_port2_attention_indicator;
      func_vec[2][7] = i_port3_attention_indicator_alt;
   end

   // Next state: config access, EEPROM load, strap capture and input routing
   always_comb begin
      d        = q;
      d.rvalid = 1'b0;
      d.pin_in = i_pin_in;
      // Strap is caught on the first enabled edge after reset release
      if (!q.strap_done) begin
         d.strap      = i_port3_hotplug_strap;  // R9
         d.strap_done = 1'b1;
      end
      // Bit 15 has no storage, so writes to it vanish
      if (i_cfg_wr && i_cfg_addr == PFS_OFF_FUNC_SEL) begin
         if (i_cfg_be[0]) begin
            d.sel[7:0] = i_cfg_wdata[7:0];
         end
         if (i_cfg_be[1]) begin
            d.sel[14:8] = i_cfg_wdata[14:8];  // R1
         end
      end
      // EEPROM load wins over a colliding config write, it runs only at init
      if (i_eeprom_load) begin
         d.sel = i_eeprom_word[14:0];  // R8
      end
      if (i_cfg_wr && i_cfg_addr == PFS_OFF_PIN_DATA && i_cfg_be[1]) begin
         for (int p = 0; p < PFS_NPINS; p++) begin
            if (gp_mode[p]) begin
               d.gp_out[p] = i_cfg_wdata[PFS_DATA_LSB + p];  // R12
            end
         end
      end
      if (i_cfg_rd) begin
         d.rvalid = 1'b1;
         case (i_cfg_addr)
            PFS_OFF_FUNC_SEL: d.rdata = {17'h00000, q.sel};  // R1
            PFS_OFF_PIN_DATA: d.rdata = {17'h00000, q.pin_in, 10'h000};  // R11
            default:          d.rdata = 32'h00000000;
         endcase
      end
      // Several pins may pick one function; their levels are ORed
      d.hp = '0;
      d.hp[PFS_HP_PF1]  = (!q.strap && sel_f[0] == PFS_SEL_ALT4 && q.pin_in[0])  // R7
                        | (sel_f[1] == PFS_SEL_ALT4 && q.pin_in[1]);  // R6
      d.hp[PFS_HP_PF2]  = (!q.strap && sel_f[0] == PFS_SEL_ALT5 && q.pin_in[0])
                        | (sel_f[1] == PFS_SEL_ALT5 && q.pin_in[1]);
      d.hp[PFS_HP_LAT1] = (!q.strap && sel_f[0] == PFS_SEL_ALT6 && q.pin_in[0])
                        | (sel_f[1] == PFS_SEL_ALT6 && q.pin_in[1]);
      d.hp[PFS_HP_LAT2] = (!q.strap && sel_f[0] == PFS_SEL_ALT7 && q.pin_in[0])
                        | (sel_f[1] == PFS_SEL_ALT7 && q.pin_in[1]);
      d.hp[PFS_HP_BTN1] = !q.strap && sel_f[0] == PFS_SEL_ALT2 && q.pin_in[0];  // R7
      d.hp[PFS_HP_BTN2] = !q.strap && sel_f[0] == PFS_SEL_ALT3 && q.pin_in[0];
      d.hp[PFS_HP_CKR3] = sel_f[1] == PFS_SEL_ALT2 && q.pin_in[1];  // R6
      d.hp[PFS_HP_LAT3] = sel_f[1] == PFS_SEL_ALT3 && q.pin_in[1];
      d.hp[PFS_HP_PF3]  = sel_f[4] == PFS_SEL_ALT7 && q.pin_in[4];  // R3
      d.hp[PFS_HP_PGD3] = q.strap && q.pin_in[0];  // R9
   end

   // Only the fundamental reset clears the selectors; lesser resets never reach here
   always_ff @(posedge i_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         q <= '{sel: PFS_FUNC_SEL_RST, gp_out: PFS_GP_OUT_RST, default: '0};  // R2 R8
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_cfg_rdata              = q.rdata;
   assign o_cfg_rvalid             = q.rvalid;
   assign o_port1_power_fault      = q.hp[PFS_HP_PF1];
   assign o_port2_power_fault      = q.hp[PFS_HP_PF2];
   assign o_port3_power_fault      = q.hp[PFS_HP_PF3];
   assign o_port3_clock_request    = q.hp[PFS_HP_CKR3];
   assign o_port1_latch_sensor     = q.hp[PFS_HP_LAT1];
   assign o_port2_latch_sensor     = q.hp[PFS_HP_LAT2];
   assign o_port3_latch_sensor     = q.hp[PFS_HP_LAT3];
   assign o_port1_attention_button = q.hp[PFS_HP_BTN1];
   assign o_port2_attention_button = q.hp[PFS_HP_BTN2];
   assign o_port3_power_good       = q.hp[PFS_HP_PGD3];

   AST_RSVD_READS_ZERO: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && i_cfg_rd && i_cfg_addr == PFS_OFF_FUNC_SEL)
      |=> (o_cfg_rvalid && o_cfg_rdata[31:PFS_RSVD_BIT] == 17'h00000))  // R1
      else $error("reserved bits of function select read nonzero");
   AST_FUNC_WRITE_READBACK: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && i_cfg_wr && i_cfg_addr == PFS_OFF_FUNC_SEL && i_cfg_be[1:0] == 2'b11
       && !i_eeprom_load) |=> (q.sel == $past(i_cfg_wdata[14:0])))  // R2
      else $error("function select write not stored");
   AST_PIN14_FAULT: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && sel_f[4] == PFS_SEL_ALT7 && q.pin_in[4]) |=> o_port3_power_fault)  // R3
      else $error("pin 14 power fault not routed");
   AST_PIN13_ATTENTION: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && sel_f[3] == PFS_SEL_ALT5)
      |=> (!o_pin_oe_n[3] && o_pin_out[3] == $past(i_port1_attention_indicator)))  // R4
      else $error("pin 13 attention indicator not driven");
   AST_PIN12_ALT_ATTN: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && sel_f[2] == PFS_SEL_ALT7)
      |=> (o_pin_out[2] == $past(i_port3_attention_indicator_alt)))  // R5
      else $error("pin 12 alternate attention not driven");
   AST_PIN11_CLKREQ: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && sel_f[1] == PFS_SEL_ALT2) |=> (o_port3_clock_request == $past(q.pin_in[1])))  // R6
      else $error("pin 11 clock request not routed");
   AST_PIN10_BUTTON: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && !q.strap && sel_f[0] == PFS_SEL_ALT2 && q.pin_in[0])
      |=> (o_port1_attention_button && o_pin_oe_n[0]))  // R7
      else $error("pin 10 button not routed");
   AST_EEPROM_LOAD: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && i_eeprom_load) |=> (q.sel == $past(i_eeprom_word[14:0])))  // R8
      else $error("EEPROM word not loaded");
   AST_STRAP_POWER_GOOD: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && q.strap) |=> (o_pin_oe_n[0] && o_port3_power_good == $past(q.pin_in[0])
       && !o_port1_attention_button && !o_port2_attention_button))  // R9
      else $error("strapped pin 10 not a power-good input");
   AST_DATA_READ_LEVELS: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && i_cfg_rd && i_cfg_addr == PFS_OFF_PIN_DATA)
      |=> (o_cfg_rdata[14:10] == $past(q.pin_in)))  // R11
      else $error("pin data read does not show pin levels");
   AST_DATA_WRITE_MASKED: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
      (i_ce && i_cfg_wr && i_cfg_addr == PFS_OFF_PIN_DATA && !gp_mode[4])
      |=> $stable(q.gp_out[4]))  // R12
      else $error("pin data write changed a non-output pin");

endmodule

// ==== test/pfs_function_select_test.sv ====
`timescale 1ns/100ps

module pfs_function_select_test import pfs_pkg::*;;
   logic        clk;
   logic        rst_n;
   logic        cfg_wr;
   logic        cfg_rd;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata;
   logic [31:0] cfg_rdata;
   logic        cfg_rvalid;
   logic        ee_load;
   logic [15:0] ee_word;
   logic        strap;
   logic [4:0]  pin_in;
   logic [4:0]  pin_out;
   logic [4:0]  pin_oe_n;
   logic [8:0]  ind;
   wire  [9:0]  hp;
   int          n_mismatch  = 0;
   int          check_count = 0;

   // Indicator index per code for pins 12..14 (act1..3, pwr1/2, pwr3 alt, att1/2, att3 alt)
   localparam int OUT_SRC [3][8] = '{'{-1, -1, 0, 1, 2, 3, 7, 8},
                                     '{-1, -1, 0, 1, 2, 6, 4, 5},
                                     '{-1, -1, 0, 1, 2, 3, 4, -1}};
   // Hot-plug output bit per code for pins 10, 11 and 14
   localparam int IN_DST [3][8]  = '{'{-1, -1, 7, 8, 0, 1, 4, 5},
                                     '{-1, -1, 3, 6, 0, 1, 4, 5},
                                     '{-1, -1, -1, -1, -1, -1, -1, 2}};
   localparam int IN_PIN [3]     = '{0, 1, 4};

   pfs_function_select pfs_function_select_i (
      .i_clk                           (clk),
      .i_rst_n                         (rst_n),
      .i_ce                            (1'b1),
      .i_cfg_wr                        (cfg_wr),
      .i_cfg_rd                        (cfg_rd),
      .i_cfg_addr                      (cfg_addr),
      .i_cfg_be                        (cfg_be),
      .i_cfg_wdata                     (cfg_wdata),
      .o_cfg_rdata                     (cfg_rdata),
      .o_cfg_rvalid                    (cfg_rvalid),
      .i_eeprom_load                   (ee_load),
      .i_eeprom_word                   (ee_word),
      .i_port3_hotplug_strap           (strap),
      .i_pin_in                        (pin_in),
      .o_pin_out                       (pin_out),
      .o_pin_oe_n                      (pin_oe_n),
      .i_port1_activity_indicator      (ind[0]),
      .i_port2_activity_indicator      (ind[1]),
      .i_port3_activity_indicator      (ind[2]),
      .i_port1_power_indicator         (ind[3]),
      .i_port2_power_indicator         (ind[4]),
      .i_port3_power_indicator_alt     (ind[5]),
      .i_port1_attention_indicator     (ind[6]),
      .i_port2_attention_indicator     (ind[7]),
      .i_port3_attention_indicator_alt (ind[8]),
      .o_port1_power_fault             (hp[0]),
      .o_port2_power_fault             (hp[1]),
      .o_port3_power_fault             (hp[2]),
      .o_port3_clock_request           (hp[3]),
      .o_port1_latch_sensor            (hp[4]),
      .o_port2_latch_sensor            (hp[5]),
      .o_port3_latch_sensor            (hp[6]),
      .o_port1_attention_button        (hp[7]),
      .o_port2_attention_button        (hp[8]),
      .o_port3_power_good              (hp[9])
   );

   // 200 MHz core clock
   always #2.5 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Every drive lands 1 ns after a rising edge, never on it
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      step(1);
      cfg_wr = 1'b0;
      // One idle edge so a following access never re-raises the strobe in this time step
      step(1);
   endtask

   // Read answer is a one-cycle pulse, so it is looked at right after the taking edge
   task automatic read_expect(input logic [7:0] a, input logic [31:0] exp);
      cfg_rd = 1'b1;
      cfg_addr = a;
      step(1);
      cfg_rd = 1'b0;
      check("rvalid", {31'h0, cfg_rvalid}, 32'h1);
      check("rdata", cfg_rdata, exp);
      step(1);
   endtask

   // Write one selector field, all other fields back to general input
   task automatic set_sel(input int p, input logic [2:0] c);
      cfg_write(PFS_OFF_FUNC_SEL, 4'h3, 32'(c) << (3 * p));
      step(2);
   endtask

   // Strap must be steady before release, it is caught once
   task automatic do_reset(input logic s);
      strap = s;
      rst_n = 1'b0;
      step(5);
      rst_n = 1'b1;
      step(4);
   endtask

   task automatic t_reset();
      read_expect(PFS_OFF_FUNC_SEL, 32'h0);
      check("oe_n", 32'(pin_oe_n), 32'h1f);
      check("hotplug", 32'(hp), 32'h0);
   endtask

   task automatic t_reserved();
      cfg_write(PFS_OFF_FUNC_SEL, 4'h3, 32'hffff);
      read_expect(PFS_OFF_FUNC_SEL, 32'h7fff);
      cfg_write(PFS_OFF_FUNC_SEL, 4'h1, 32'h0);
      read_expect(PFS_OFF_FUNC_SEL, 32'h7f00);
      read_expect(8'h80, 32'h0);
      cfg_write(PFS_OFF_FUNC_SEL, 4'h3, 32'h0);
   endtask

   // Each indicator code is checked with its source high among lows and low among highs
   task automatic t_out_map();
      int src;
      logic [1:0] seen;
      logic [1:0] exp;
      for (int p = 2; p < 5; p++) begin
         for (int c = 2; c < 8; c++) begin
            src = OUT_SRC[p-2][c];
            set_sel(p, 3'(c));
            for (int k = 0; k < 2; k++) begin
               ind = (src < 0) ? 9'h1ff : (9'h1 << src) ^ {9{k[0]}};
               step(2);
               seen = {pin_oe_n[p], pin_out[p]};
               exp = (src < 0) ? 2'b10 : {1'b0, ~k[0]};
               case (p)
                  2: check("pin12 drive", 32'(seen), 32'(exp));
                  3: check("pin13 drive", 32'(seen), 32'(exp));
                  default: check("pin14 drive", 32'(seen), 32'(exp));
               endcase
            end
         end
      end
      ind = 9'h0;
   endtask

   // Pin levels reach only the selected hot-plug input and the pin stays undriven
   task automatic t_in_map();
      int pin;
      int dst;
      logic [10:0] exp;
      for (int j = 0; j < 3; j++) begin
         pin = IN_PIN[j];
         for (int c = 2; c < 8; c++) begin
            dst = IN_DST[j][c];
            if (dst >= 0) begin
               set_sel(pin, 3'(c));
               pin_in = 5'h1 << pin;
               step(3);
               exp = {1'b1, 10'h1 << dst};
               case (j)
                  0: check("pin10 route", 32'({pin_oe_n[pin], hp}), 32'(exp));
                  1: check("pin11 route", 32'({pin_oe_n[pin], hp}), 32'(exp));
                  default: check("pin14 route", 32'({pin_oe_n[pin], hp}), 32'(exp));
               endcase
               pin_in = 5'h0;
               step(3);
               check("route idle", 32'(hp), 32'h0);
            end
         end
      end
   endtask

   task automatic t_gp_out();
      cfg_write(PFS_OFF_FUNC_SEL, 4'h3, 32'h2441);
      cfg_write(PFS_OFF_PIN_DATA, 4'h2, 32'h7c00);
      step(2);
      check("pin_out", 32'(pin_out), 32'h05);
      check("oe_n", 32'(pin_oe_n), 32'h02);
      cfg_write(PFS_OFF_PIN_DATA, 4'h2, 32'h0);
      step(2);
      check("pin_out", 32'(pin_out), 32'h0);
      pin_in = 5'b10110;
      step(3);
      read_expect(PFS_OFF_PIN_DATA, 32'h5800);
      pin_in = 5'h0;
   endtask

   task automatic t_eeprom();
      ee_word = 16'hffff;
      ee_load = 1'b1;
      step(1);
      ee_load = 1'b0;
      read_expect(PFS_OFF_FUNC_SEL, 32'h7fff);
      ee_word = 16'h1249;
      ee_load = 1'b1;
      cfg_write(PFS_OFF_FUNC_SEL, 4'h3, 32'h0);
      ee_load = 1'b0;
      read_expect(PFS_OFF_FUNC_SEL, 32'h1249);
      do_reset(1'b0);
      read_expect(PFS_OFF_FUNC_SEL, 32'h0);
   endtask

   // Strapped pin 10 ignores its selector even when software sets it anyway
   task automatic t_strap();
      do_reset(1'b1);
      cfg_write(PFS_OFF_FUNC_SEL, 4'h3, 32'h1);
      cfg_write(PFS_OFF_PIN_DATA, 4'h2, 32'h7c00);
      pin_in = 5'h01;
      step(3);
      check("pin10 drive", 32'({pin_oe_n[0], pin_out[0]}), 32'h2);
      check("power good", 32'(hp), 32'h200);
      set_sel(0, 3'b010);
      step(1);
      check("power good", 32'(hp), 32'h200);
      pin_in = 5'h0;
      step(3);
      check("power good", 32'(hp), 32'h0);
      // Software hands the strapped pin selector back to its default
      cfg_write(PFS_OFF_FUNC_SEL, 4'h3, 32'h0);
      read_expect(PFS_OFF_FUNC_SEL, 32'h0);
      do_reset(1'b0);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0;
      ee_load = 1'b0;
      ee_word = 16'h0;
      strap = 1'b0;
      pin_in = 5'h0;
      ind = 9'h0;
      do_reset(1'b0);
      t_reset();
      t_reserved();
      t_out_map();
      t_in_map();
      t_gp_out();
      t_eeprom();
      t_strap();
      wrap_up();
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end
endmodule
